// ---- hdl/scsc_clk_ctrl.sv ----
// System clock and standby control: registers, clock selection, state clock,
// warm-up timer and standby mode decode.
// Assumes oscillator and hardware standby pins are asynchronous levels and
// that halt_active and doubler_active come from logic on core_clk.
`include "scsc_consts.svh"
`default_nettype none
module scsc_clk_ctrl
   import scsc_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        srst,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [11:0] wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        fast_clk_pin,
   input  wire logic        slow_clk_pin,
   input  wire logic        hw_standby_pin,
   input  wire logic        halt_active,
   input  wire logic        doubler_active,
   output logic             fast_osc_enable_q,
   output logic             slow_osc_enable_q,
   output logic             fast_osc_after_wake_q,
   output logic             slow_osc_after_wake_q,
   output logic             clock_after_wake_select_q,
   output logic      [1:0]  prescaler_source_q,
   output logic             power_save_disable_q,
   output logic             core_tick_q,
   output logic             state_tick_q,
   output scsc_mode_t       standby_mode_q,
   output scsc_arr_t        arrangement_q,
   output logic             pin_hold_q
);
   // -----------------------------------------------------------------
   // Pin synchronisers
   // -----------------------------------------------------------------
   logic fast_s1_q;
   logic fast_s2_q;
   logic fast_s3_q;
   logic slow_s1_q;
   logic slow_s2_q;
   logic slow_s3_q;
   logic stby_s1_q;
   logic stby_s2_q;

   // Two flops per pin; the third flop only serves edge detection
   always_ff @(posedge core_clk) begin
      if (srst) begin
         {fast_s1_q, fast_s2_q, fast_s3_q} <= 3'h0;
         {slow_s1_q, slow_s2_q, slow_s3_q} <= 3'h0;
         {stby_s1_q, stby_s2_q}            <= 2'h0;
      end else begin
         {fast_s1_q, fast_s2_q, fast_s3_q} <= {fast_clk_pin, fast_s1_q, fast_s2_q};
         {slow_s1_q, slow_s2_q, slow_s3_q} <= {slow_clk_pin, slow_s1_q, slow_s2_q};
         {stby_s1_q, stby_s2_q}            <= {hw_standby_pin, stby_s1_q};
      end
   end

   // -----------------------------------------------------------------
   // Register file
   // -----------------------------------------------------------------
   logic [7:0]  osc_q;
   logic [7:0]  clk_q;
   logic [7:0]  stby_q;
   logic        req;
   logic        wr;
   logic        hit_osc;
   logic        hit_clk;
   logic        hit_stby;
   logic        warm_start;
   logic        warm_busy;
   logic [7:0]  rd_byte;
   logic [7:0]  osc_d;
   logic [7:0]  clk_d;
   logic [7:0]  stby_d;

   // Decode; a new request is taken only while ack is low
   assign req        = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr         = req && wb_we_i && wb_sel_i[0];
   assign hit_osc    = wb_adr_i[11:2] == `SCSC_IDX_OSC;
   assign hit_clk    = wb_adr_i[11:2] == `SCSC_IDX_CLK;
   assign hit_stby   = wb_adr_i[11:2] == `SCSC_IDX_STBY;
   assign warm_start = wr && hit_osc && wb_dat_i[`SCSC_B_WARM];
   // Warm-up bit is never stored; writing 0 does nothing
   assign osc_d      = (wr && hit_osc) ?
                       (wb_dat_i[7:0] & ~(8'h01 << `SCSC_B_WARM)) : osc_q;
   assign clk_d      = (wr && hit_clk) ? (wb_dat_i[7:0] & `SCSC_MASK_CLK) : clk_q;
   assign stby_d     = (wr && hit_stby) ? (wb_dat_i[7:0] & `SCSC_MASK_STBY) : stby_q;
   // Unmapped addresses read zero and still ack
   assign rd_byte    = hit_osc  ? (osc_q | ({7'h00, warm_busy} << `SCSC_B_WARM)) :
                       hit_clk  ? clk_q :
                       hit_stby ? stby_q : 8'h00;

   // Register storage and bus answer
   always_ff @(posedge core_clk) begin
      if (srst) begin
         osc_q    <= `SCSC_RST_OSC;
         clk_q    <= `SCSC_RST_CLK;
         stby_q   <= `SCSC_RST_STBY;
         wb_ack_o <= 1'h0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         osc_q    <= osc_d;
         clk_q    <= clk_d;
         stby_q   <= stby_d;
         wb_ack_o <= req;
         wb_dat_o <= req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
   end

   // -----------------------------------------------------------------
   // Clock sources and selection
   // -----------------------------------------------------------------
   logic fast_tick;
   logic slow_tick;
   logic geared_tick;
   logic system_clock_select;
   logic core_d;
   logic phase_q;

   // A stopped oscillator contributes no ticks
   assign fast_tick = fast_s2_q && !fast_s3_q && osc_q[`SCSC_B_FAST_EN];
   assign slow_tick = slow_s2_q && !slow_s3_q && osc_q[`SCSC_B_SLOW_EN];
   assign system_clock_select     = clk_q[`SCSC_B_SYSTEM_CLOCK_SELECT];

   scsc_gear_div u_gear (
      .core_clk      (core_clk),
      .srst          (srst),
      .fast_tick     (fast_tick),
      .gear_code     (clk_q[2:0]),
      .geared_tick_q (geared_tick)
   );

   // Slow tick is delayed one flop so both paths have equal latency
   logic slow_dly_q;
   assign core_d = system_clock_select ? slow_dly_q : geared_tick;

   // Core tick and state clock divide by two
   always_ff @(posedge core_clk) begin
      if (srst) begin
         slow_dly_q   <= 1'h0;
         core_tick_q  <= 1'h0;
         phase_q      <= 1'h0;
         state_tick_q <= 1'h0;
      end else begin
         slow_dly_q   <= slow_tick;
         core_tick_q  <= core_d;
         phase_q      <= core_tick_q ? !phase_q : phase_q;
         state_tick_q <= core_tick_q && phase_q;
      end
   end

   // -----------------------------------------------------------------
   // Warm-up timer
   // -----------------------------------------------------------------
   logic [16:0] warm_cnt_q;
   logic [16:0] warm_cnt_d;
   logic [16:0] warm_load;
   logic        src_tick;

   // Counts ticks of the oscillator that drives the core clock
   assign src_tick  = system_clock_select ? slow_tick : fast_tick;
   // Reserved time code takes the shortest time
   assign warm_load = (stby_q[5:4] == 2'h3) ? `SCSC_WARM_T11 :
                      (stby_q[5:4] == 2'h2) ? `SCSC_WARM_T10 : `SCSC_WARM_T01;
   assign warm_busy = warm_cnt_q != 17'h0_0000;
   assign warm_cnt_d = warm_start ? warm_load :
                       (warm_busy && src_tick) ? 17'(warm_cnt_q - 17'h0_0001) : warm_cnt_q;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         warm_cnt_q <= 17'h0_0000;
      end else begin
         warm_cnt_q <= warm_cnt_d;
      end
   end

   // -----------------------------------------------------------------
   // Standby decode, pin drive and arrangement
   // -----------------------------------------------------------------
   scsc_mode_t mode_d;
   scsc_arr_t  arr_d;
   logic       in_stby;
   logic       hold_d;
   logic [1:0] halt_code;

   assign in_stby   = halt_active || stby_s2_q;
   assign halt_code = stby_q[3:2];

   // Hardware standby reads code 11 as light idle; reserved code stays running
   always_comb begin
      mode_d = SCSC_RUN;
      if (in_stby) begin
         unique case (halt_code)
            `SCSC_HALT_STOP:  mode_d = SCSC_STOP;
            `SCSC_HALT_IDLE_LIGHT: mode_d = SCSC_IDLE_LIGHT;
            `SCSC_HALT_IDLE_PERIPHERAL: mode_d = stby_s2_q ? SCSC_IDLE_LIGHT : SCSC_IDLE_PERIPH;
            default:          mode_d = SCSC_RUN;
         endcase
      end
   end

   // Select bit polarity is the reverse of the halt code sense
   assign hold_d = stby_q[`SCSC_B_KEEP] &&
                   ((mode_d == SCSC_IDLE_LIGHT && !stby_q[`SCSC_B_PIN_DRIVE_MODE_SELECT]) ||
                    (mode_d == SCSC_STOP && stby_q[`SCSC_B_PIN_DRIVE_MODE_SELECT]));
   assign arr_d  = !osc_q[`SCSC_B_SLOW_EN] ? SCSC_SINGLE :
                   doubler_active ? SCSC_TRIPLE : SCSC_DUAL;

   // Registered outputs
   always_ff @(posedge core_clk) begin
      if (srst) begin
         standby_mode_q <= SCSC_RUN;
         arrangement_q  <= SCSC_DUAL;
         pin_hold_q     <= 1'h0;
      end else begin
         standby_mode_q <= mode_d;
         arrangement_q  <= arr_d;
         pin_hold_q     <= hold_d;
      end
   end

   // Register fields as outputs
   assign fast_osc_enable_q         = osc_q[`SCSC_B_FAST_EN];
   assign slow_osc_enable_q         = osc_q[`SCSC_B_SLOW_EN];
   assign fast_osc_after_wake_q     = osc_q[`SCSC_B_FAST_WAKE];
   assign slow_osc_after_wake_q     = osc_q[`SCSC_B_SLOW_WAKE];
   assign clock_after_wake_select_q = osc_q[`SCSC_B_CLK_WAKE];
   assign prescaler_source_q        = osc_q[1:0];
   assign power_save_disable_q      = stby_q[`SCSC_B_PSDIS];

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   property p_arrangement;
      !slow_osc_enable_q |=> (arrangement_q == SCSC_SINGLE);
   endproperty
   a_arrangement: assert property (p_arrangement) else $error("arrangement not single");

   // Three quiet cycles flush the gear and core tick flops
   property p_fast_src;
      (!fast_osc_enable_q && !system_clock_select) [*3] |-> !core_tick_q;
   endproperty
   a_fast_src: assert property (p_fast_src) else $error("core tick from stopped osc");

   property p_core_sel;
      ##1 core_tick_q == $past(core_d);
   endproperty
   a_core_sel: assert property (p_core_sel) else $error("core tick wrong source");

   property p_state_div;
      state_tick_q |-> $past(core_tick_q) && $past(phase_q);
   endproperty
   a_state_div: assert property (p_state_div) else $error("state tick without core tick");

   property p_state_half;
      (core_tick_q && !phase_q) |=> !state_tick_q;
   endproperty
   a_state_half: assert property (p_state_half) else $error("state tick every core tick");

   property p_hw_idle;
      (stby_s2_q && halt_code == 2'h3) |=> (standby_mode_q == SCSC_IDLE_LIGHT);
   endproperty
   a_hw_idle: assert property (p_hw_idle) else $error("hw standby code 11 not light idle");

   property p_pin_drive_mode_select;
      (stby_q[`SCSC_B_KEEP] && stby_q[`SCSC_B_PIN_DRIVE_MODE_SELECT] && mode_d == SCSC_STOP) |=> pin_hold_q;
   endproperty
   a_pin_drive_mode_select: assert property (p_pin_drive_mode_select) else $error("stop pin hold missing");

   property p_warm_start;
      warm_start |=> warm_busy [*8];
   endproperty
   a_warm_start: assert property (p_warm_start) else $error("warm-up flag not set");

   property p_warm_hold;
      (warm_busy && !src_tick && !warm_start) |=> $stable(warm_cnt_q);
   endproperty
   a_warm_hold: assert property (p_warm_hold) else $error("warm-up count moved without tick");

   property p_ack_once;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");

   c_slow_run: cover property (system_clock_select && core_tick_q);
   c_warm_end: cover property (warm_busy ##1 !warm_busy);
   c_hw_idle:  cover property (standby_mode_q == SCSC_IDLE_LIGHT && stby_s2_q);
endmodule : scsc_clk_ctrl
`default_nettype wire

// ---- hdl/scsc_consts.svh ----
// Constants of the system clock and standby control block.
// Assumes a 32-bit classic Wishbone slave port on a single 100 MHz core clock.
//
// Contract
// - Report single, dual or triple clock arrangement from oscillator and doubler state.
// - Fast pin feeds the fast clock, slow pin feeds the slow clock.
// - Core clock is geared fast clock or slow clock per select bit.
// - State clock is core clock divided by two; one period is one state.
// - Under hardware standby, halt type code 11 means light idle.
// - Pin drive mode select 0 applies to light idle, 1 to stop.
`ifndef SCSC_CONSTS_SVH
`define SCSC_CONSTS_SVH

// -----------------------------------------------------------------
// Register indices (byte address is four times the index)
// -----------------------------------------------------------------
`define SCSC_IDX_OSC         10'h0e0
`define SCSC_IDX_CLK         10'h0e1
`define SCSC_IDX_STBY        10'h0e2

// -----------------------------------------------------------------
// Reset values and read masks
// -----------------------------------------------------------------
`define SCSC_RST_OSC         8'he0
`define SCSC_RST_CLK         8'h04
`define SCSC_RST_STBY        8'h2c
`define SCSC_MASK_CLK        8'h0f
`define SCSC_MASK_STBY       8'hbf

// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define SCSC_B_FAST_EN       7
`define SCSC_B_SLOW_EN       6
`define SCSC_B_FAST_WAKE     5
`define SCSC_B_SLOW_WAKE     4
`define SCSC_B_CLK_WAKE      3
`define SCSC_B_WARM          2
`define SCSC_B_SYSTEM_CLOCK_SELECT         3
`define SCSC_B_PSDIS         7
`define SCSC_B_KEEP          0
`define SCSC_B_PIN_DRIVE_MODE_SELECT        1

// -----------------------------------------------------------------
// Codes and counts
// -----------------------------------------------------------------
`define SCSC_HALT_STOP       2'h1
`define SCSC_HALT_IDLE_LIGHT      2'h2
`define SCSC_HALT_IDLE_PERIPHERAL      2'h3
`define SCSC_GEAR_MAX        3'h4
`define SCSC_WARM_T01        17'h0_0100
`define SCSC_WARM_T10        17'h0_4000
`define SCSC_WARM_T11        17'h1_0000

`endif

// ---- hdl/scsc_pkg.sv ----
// Types shared by the system clock and standby control block.
// Assumes the constants header is compiled alongside.
`default_nettype none
package scsc_pkg;
   // Standby state currently presented to the rest of the chip
   typedef enum logic [1:0] {SCSC_RUN, SCSC_STOP, SCSC_IDLE_LIGHT, SCSC_IDLE_PERIPH} scsc_mode_t;
   // Clock arrangement in use
   typedef enum logic [1:0] {SCSC_SINGLE, SCSC_DUAL, SCSC_TRIPLE} scsc_arr_t;
endpackage : scsc_pkg
`default_nettype wire

// ---- hdl/scsc_gear_div.sv ----
// Clock gear: divides fast clock ticks by 1, 2, 4, 8 or 16.
// Assumes fast_tick is a one-cycle pulse already in the core_clk domain.
`include "scsc_consts.svh"
`default_nettype none
module scsc_gear_div
   import scsc_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       srst,
   input  wire logic       fast_tick,
   input  wire logic [2:0] gear_code,
   output logic            geared_tick_q
);
   // -----------------------------------------------------------------
   // Divider
   // -----------------------------------------------------------------
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic [3:0] mask;
   logic [2:0] code_eff;
   logic       hit;

   // Reserved codes fall back to the slowest gear rather than stopping
   assign code_eff = (gear_code > `SCSC_GEAR_MAX) ? `SCSC_GEAR_MAX : gear_code;
   assign mask     = 4'((5'h01 << code_eff) - 5'h01);
   assign hit      = fast_tick && ((cnt_q & mask) == mask);
   assign cnt_d    = fast_tick ? 4'(cnt_q + 4'h1) : cnt_q;

   // Counter and registered output tick
   always_ff @(posedge core_clk) begin
      if (srst) begin
         cnt_q         <= 4'h0;
         geared_tick_q <= 1'h0;
      end else begin
         cnt_q         <= cnt_d;
         geared_tick_q <= hit;
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   property p_gear_one;
      @(posedge core_clk) disable iff (srst)
         (fast_tick && gear_code == 3'h0) |=> geared_tick_q;
   endproperty
   a_gear_one: assert property (p_gear_one) else $error("gear 1 did not pass tick");

   property p_gear_quiet;
      @(posedge core_clk) disable iff (srst)
         !fast_tick |=> !geared_tick_q;
   endproperty
   a_gear_quiet: assert property (p_gear_quiet) else $error("gear tick without source");
endmodule : scsc_gear_div
`default_nettype wire

// ---- test/scsc_testbench.sv ----
// Self-checking bench for the system clock and standby control block.
// Assumes scsc_pkg is compiled first and scsc_clk_ctrl holds its own assertions.
`default_nettype none
module testbench
   import scsc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // -----------------------------------------------------------------
   // Signals and design under test
   // -----------------------------------------------------------------
   localparam logic [11:0] ADR_OSC  = 12'h380;
   localparam logic [11:0] ADR_CLK  = 12'h384;
   localparam logic [11:0] ADR_STBY = 12'h388;

   logic        core_clk = 1'b0;
   logic        srst = 1'b1;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0;
   logic [11:0] wb_adr_i = 12'h000;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0000_0000;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        fast_clk_pin = 1'b0;
   logic        slow_clk_pin = 1'b0;
   logic        hw_standby_pin = 1'b0;
   logic        halt_active = 1'b0;
   logic        doubler_active = 1'b0;
   logic        fast_en, slow_en, core_tick_q, state_tick_q, pin_hold_q;
   logic        fast_wake, slow_wake, clk_wake, psdis;
   logic [1:0]  presc;
   scsc_mode_t  standby_mode_q;
   scsc_arr_t   arrangement_q;
   logic [3:0]  div_q = 4'h0;
   logic        counting = 1'b0;
   int          core_cnt, state_cnt, miscompares, checks;

   scsc_clk_ctrl u_scsc_clk_ctrl (
      .core_clk(core_clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fast_clk_pin(fast_clk_pin),
      .slow_clk_pin(slow_clk_pin), .hw_standby_pin(hw_standby_pin),
      .halt_active(halt_active), .doubler_active(doubler_active),
      .fast_osc_enable_q(fast_en), .slow_osc_enable_q(slow_en),
      .fast_osc_after_wake_q(fast_wake), .slow_osc_after_wake_q(slow_wake),
      .clock_after_wake_select_q(clk_wake), .prescaler_source_q(presc),
      .power_save_disable_q(psdis), .core_tick_q(core_tick_q),
      .state_tick_q(state_tick_q), .standby_mode_q(standby_mode_q),
      .arrangement_q(arrangement_q), .pin_hold_q(pin_hold_q));

   `define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin miscompares++; \
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp); end end

   // -----------------------------------------------------------------
   // Clock, oscillator pins and tick counters
   // -----------------------------------------------------------------
   // Core clock of 100 MHz
   always #5 core_clk = ~core_clk;

   // Fast pin rises every 4 cycles, slow pin every 16, far slower as on the board
   always @(posedge core_clk) begin
      div_q <= div_q + 4'h1;
      fast_clk_pin <= div_q[1];
      slow_clk_pin <= div_q[3];
   end

   // Count output ticks only inside a measuring window
   always @(posedge core_clk) begin
      if (counting && core_tick_q === 1'b1) core_cnt++;
      if (counting && state_tick_q === 1'b1) state_cnt++;
   end

   // -----------------------------------------------------------------
   // Bus and helper tasks
   // -----------------------------------------------------------------
   // One classic cycle; waits for ack as long as it takes, only the watchdog ends a hang
   task automatic wb(input logic we, input logic [11:0] adr, input logic [7:0] dat,
                     input logic [3:0] sel, output logic [31:0] rd);
      @(posedge core_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_sel_i <= sel;
      wb_dat_i <= {24'h00_0000, dat};
      do begin
         @(posedge core_clk);
      end while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask : wb

   task automatic wr(input logic [11:0] adr, input logic [7:0] dat);
      logic [31:0] rd;
      wb(1'b1, adr, dat, 4'hf, rd);
   endtask : wr

   task automatic rd_chk(input logic [11:0] adr, input logic [7:0] exp);
      logic [31:0] rd;
      wb(1'b0, adr, 8'h00, 4'hf, rd);
      `CHK(rd, {24'h00_0000, exp})
   endtask : rd_chk

   // Measure core and state ticks over a window of cycles
   task automatic count(input int cyc);
      core_cnt = 0;
      state_cnt = 0;
      @(posedge core_clk);
      counting <= 1'b1;
      repeat (cyc) @(posedge core_clk);
      counting <= 1'b0;
      @(posedge core_clk);
   endtask : count

   function automatic logic near(input int a, input int e);
      return (a >= e - 1) && (a <= e + 1);
   endfunction : near

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   // Reset values, read masks, unmapped place and a write without lane 0
   task automatic t_regs;
      rd_chk(ADR_OSC, 8'he0);
      rd_chk(ADR_CLK, 8'h04);
      rd_chk(ADR_STBY, 8'h2c);
      `CHK(psdis, 1'b0)
      rd_chk(12'h38c, 8'h00);
      wr(12'h38c, 8'hff);
      wb(1'b1, ADR_CLK, 8'h0b, 4'he, core_cnt);
      rd_chk(ADR_CLK, 8'h04);
      wr(ADR_CLK, 8'hff);
      rd_chk(ADR_CLK, 8'h0f);
      wr(ADR_STBY, 8'hff);
      rd_chk(ADR_STBY, 8'hbf);
      `CHK(psdis, 1'b1)
      // Wake choices and prescaler source reach their outputs; both oscillators stay on
      wr(ADR_OSC, 8'hdb);
      rd_chk(ADR_OSC, 8'hdb);
      `CHK({fast_wake, slow_wake, clk_wake, presc}, 5'h0f)
      wr(ADR_OSC, 8'he0);
      $display("test regs done");
   endtask : t_regs

   // Every gear code plus a reserved one; state clock is half the core clock
   task automatic t_gear;
      for (int code = 0; code < 6; code++) begin
         wr(ADR_CLK, 8'(code));
         repeat (40) @(posedge core_clk);
         count(256);
         `CHK(near(core_cnt, 64 >> (code > 4 ? 4 : code)), 1'b1)
         `CHK(near(state_cnt, core_cnt / 2), 1'b1)
      end
      wr(ADR_CLK, 8'h08);
      repeat (40) @(posedge core_clk);
      count(256);
      `CHK(near(core_cnt, 16), 1'b1)
      `CHK(near(state_cnt, 8), 1'b1)
      $display("test gear done");
   endtask : t_gear

   // Warm-up of 2^8 fast ticks; writing 0 leaves it running
   task automatic t_warm;
      wr(ADR_CLK, 8'h00);
      wr(ADR_STBY, 8'h1c);
      wr(ADR_OSC, 8'he4);
      rd_chk(ADR_OSC, 8'he4);
      wr(ADR_OSC, 8'he0);
      repeat (850) @(posedge core_clk);
      rd_chk(ADR_OSC, 8'he4);
      repeat (200) @(posedge core_clk);
      rd_chk(ADR_OSC, 8'he0);
      $display("test warm done");
   endtask : t_warm

   // Halt type decode, hardware standby override and pin keep polarity
   task automatic t_standby;
      logic [7:0] cfg [7] = '{8'h05, 8'h07, 8'h09, 8'h0b, 8'h0d, 8'h0d, 8'h00};
      scsc_mode_t mode [7] = '{SCSC_STOP, SCSC_STOP, SCSC_IDLE_LIGHT, SCSC_IDLE_LIGHT,
                               SCSC_IDLE_PERIPH, SCSC_IDLE_LIGHT, SCSC_RUN};
      logic hold [7] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
      for (int i = 0; i < 7; i++) begin
         wr(ADR_STBY, cfg[i]);
         halt_active <= (i != 5);
         hw_standby_pin <= (i == 5);
         repeat (8) @(posedge core_clk);
         `CHK(standby_mode_q, mode[i])
         `CHK(pin_hold_q, hold[i])
      end
      halt_active <= 1'b0;
      hw_standby_pin <= 1'b0;
      $display("test standby done");
   endtask : t_standby

   // Clock arrangement follows slow enable and doubler use
   task automatic t_arr;
      wr(ADR_OSC, 8'ha0);
      repeat (3) @(posedge core_clk);
      `CHK(slow_en, 1'b0)
      `CHK(arrangement_q, SCSC_SINGLE)
      wr(ADR_OSC, 8'he0);
      repeat (3) @(posedge core_clk);
      `CHK(fast_en, 1'b1)
      `CHK(arrangement_q, SCSC_DUAL)
      // Fast oscillator off while the doubler is idle: no core ticks on the fast path
      wr(ADR_OSC, 8'h60);
      count(64);
      `CHK(core_cnt, 0)
      wr(ADR_OSC, 8'he0);
      // Doubler only used while the fast clock drives the core
      doubler_active <= 1'b1;
      repeat (3) @(posedge core_clk);
      `CHK(arrangement_q, SCSC_TRIPLE)
      doubler_active <= 1'b0;
      $display("test arrangement done");
   endtask : t_arr

   // -----------------------------------------------------------------
   // Sequence, watchdog and verdict
   // -----------------------------------------------------------------
   task automatic end_of_test;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_of_test

   // Tests need well under 10000 cycles; the limit leaves ample margin
   initial begin
      #200000;
      miscompares++;
      end_of_test();
   end

   // Reset held for two cycles, then the scenarios in turn
   initial begin
      repeat (2) @(posedge core_clk);
      srst <= 1'b0;
      t_regs();
      t_gear();
      t_warm();
      t_standby();
      t_arr();
      end_of_test();
   end
endmodule : testbench
`default_nettype wire
